/* File: hdl/flash_seq_pkg.sv */
// package: register map, command codes, states, timing for the sequencer
// assumes: one 200 MHz clock, avalon-mm slave with 32-bit data
package flash_seq_pkg;
  // ==========================================================
  // register word offsets (byte address = 4 * index)
  localparam logic [3:0] off_mode_entry = 4'h0;
  localparam logic [3:0] off_start_addr = 4'h1;
  localparam logic [3:0] off_end_addr = 4'h2;
  localparam logic [3:0] off_suspend_method = 4'h3;
  localparam logic [3:0] off_seq_status = 4'h4;
  localparam logic [3:0] off_access_status = 4'h5;
  localparam logic [3:0] off_cmd_area = 4'h6;
  // ==========================================================
  // mode entry values and field positions
  localparam logic [15:0] mode_read = 16'h0000;
  localparam logic [15:0] mode_code = 16'h0001;
  localparam logic [15:0] mode_data = 16'h0080;
  localparam int code_entry_bit = 0;
  localparam int data_entry_bit = 7;
  // status field positions
  localparam int st_ready_bit = 15;
  localparam int st_suspend_ready_flag_bit = 14;
  localparam int st_erase_suspended_flag_bit = 13;
  localparam int st_program_suspended_flag_bit = 12;
  localparam int st_buf_full_bit = 10;
  localparam int st_hv_err_bit = 6;
  localparam int st_ilgl_bit = 5;
  localparam int st_addr_err_bit = 4;
  localparam int st_lock_bit = 4;
  // ==========================================================
  // command bytes
  localparam logic [7:0] cmd_program = 8'hE8;
  localparam logic [7:0] cmd_multi = 8'hEA;
  localparam logic [7:0] cmd_dma = 8'hEC;
  localparam logic [7:0] cmd_blk_erase = 8'h20;
  localparam logic [7:0] cmd_area_erase = 8'h23;
  localparam logic [7:0] cmd_suspend = 8'hB0;
  localparam logic [7:0] cmd_resume = 8'hD0;
  localparam logic [7:0] cmd_clear = 8'h50;
  localparam logic [7:0] cmd_stop = 8'hB3;
  localparam logic [7:0] cmd_final = 8'hD0;
  // ==========================================================
  // reset values
  localparam logic [15:0] mode_entry_rst = 16'h0000;
  localparam logic [31:0] addr_rst = 32'h0000_0000;
  // ==========================================================
  // timing of the modelled array
  localparam int clk_mhz = 200;
  localparam int prog_time_ns = 400;
  localparam int erase_time_ns = 2000;
  localparam int pulse_time_ns = 50;
  localparam logic [15:0] prog_cycles = 16'((prog_time_ns * clk_mhz) / 1000);
  localparam logic [15:0] erase_cycles =
    16'((erase_time_ns * clk_mhz) / 1000);
  localparam logic [15:0] pulse_cycles = 16'((pulse_time_ns * clk_mhz) / 1000);
  localparam logic [15:0] suspend_ready_flag_delay = 16'h0004;
  localparam logic [7:0] data_words_max = 8'h04;
  // ==========================================================
  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_collect = 4'b0001,
    st_wait_final = 4'b0011,
    st_busy = 4'b0010,
    st_suspending = 4'b0110,
    st_suspended = 4'b0111,
    st_dma_wait = 4'b0101,
    st_locked = 4'b0100
  } seq_state_t;

  typedef enum logic [2:0] {
    op_none = 3'h0,
    op_prog = 3'h1,
    op_multi = 3'h2,
    op_dma = 3'h3,
    op_blk = 3'h4,
    op_area = 3'h5
  } op_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } bus_rsp_t;
endpackage : flash_seq_pkg

/* File: hdl/flash_command_sequencer.sv */
// flash command sequencer: mode entry, command decode, status and lock
// assumes: avalon-mm master on mclk_in, dma controller answers dreq_out
//
// Summary of operation
// - mode bits gate command acceptance per flash
// - mode register zero returns to read mode
// - lock rejects commands until clear while ready, or stop
// - clear while ready, or stop, wipes lock source flags
// - programming loads address, starts on final d0
// - buffer never full, no extra bus waits
// - multi programming only in data mode
// - dma request after accept and each word but the last
// - block erase starts on 20 then d0
// - area erase starts on 23 then d0
// - bad area address range raises lock
// - finish before suspend: ready, no suspend flags
// - suspended shows ready plus one suspend flag
// - resume when not suspended locks with error
// - clearing mode while suspended gives read mode
// - suspend finishes pulse (erase with esuspmd 0 stops next cycle), then flags and ready together
// - resume clears ready and suspend flag
// - accept clears ready, suspend-ready set later except for dma
// - ready rising pulses flash ready event
// - illegal command locks, suspend sometimes ignored
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module flash_command_sequencer
  import flash_seq_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic dack_in,
  output logic dreq_out,
  output logic flash_ready_event_out
);

  // ==========================================================
  // state record
  typedef struct packed {
    seq_state_t state;
    op_t op;
    op_t susp_op;
    logic [15:0] mode_entry;
    logic [31:0] start_addr;
    logic [31:0] end_addr;
    logic esuspmd;
    logic ready;
    logic suspend_ready_flag;
    logic program_suspended_flag;
    logic erase_suspended_flag;
    logic hv_err;
    logic ilgl_err;
    logic addr_err;
    logic [15:0] timer;
    logic [7:0] words;
    logic susp_req;
    logic dreq;
    logic rdy_event;
    logic [31:0] rdata;
    logic ack;
  } state_t;

  state_t cur_reg;
  state_t cur_next;
  bus_req_t req;

  // true for a command byte that starts a program or erase
  function automatic logic is_start(input logic [7:0] b);
    is_start = (b == cmd_program) || (b == cmd_multi) ||
      (b == cmd_dma) || (b == cmd_blk_erase) || (b == cmd_area_erase);
  endfunction : is_start

  // decode of a start byte into an operation
  function automatic op_t op_of(input logic [7:0] b);
    case (b)
      cmd_program: op_of = op_prog;
      cmd_multi: op_of = op_multi;
      cmd_dma: op_of = op_dma;
      cmd_blk_erase: op_of = op_blk;
      cmd_area_erase: op_of = op_area;
      default: op_of = op_none;
    endcase
  endfunction : op_of

  function automatic logic is_erase(input op_t o);
    is_erase = (o == op_blk) || (o == op_area);
  endfunction : is_erase

  assign req = '{avs_address_in, avs_read_in, avs_write_in,
    avs_writedata_in};

  logic lock;
  logic in_code;
  logic in_data;
  logic acc;
  logic [7:0] cbyte;
  assign lock = cur_reg.hv_err | cur_reg.ilgl_err | cur_reg.addr_err;
  assign in_code = cur_reg.mode_entry[code_entry_bit];
  assign in_data = cur_reg.mode_entry[data_entry_bit];
  // one-cycle wait then ack; buffer never full so no extra waits
  assign acc = (req.read | req.write) & ~cur_reg.ack;
  assign cbyte = req.writedata[7:0];

  // ==========================================================
  // next state
  always_comb begin
    cur_next = cur_reg;
    cur_next.ack = 1'b0;
    cur_next.rdy_event = 1'b0;
    cur_next.dreq = 1'b0;
    // array model: timer and completion
    if (cur_reg.state == st_busy || cur_reg.state == st_suspending) begin
      if (cur_reg.timer != 16'h0000) begin
        cur_next.timer = cur_reg.timer - 16'h0001;
      end
      if (cur_reg.state == st_busy && cur_reg.op != op_dma &&
          cur_reg.timer > suspend_ready_flag_delay) begin
        cur_next.suspend_ready_flag = 1'b1;
      end
      if (cur_reg.timer == 16'h0000) begin
        cur_next.suspend_ready_flag = 1'b0;
        if (cur_reg.state == st_suspending) begin
          cur_next.state = st_suspended;
          cur_next.susp_op = cur_reg.op;
          if (is_erase(cur_reg.op)) begin
            cur_next.erase_suspended_flag = 1'b1;
          end else begin
            cur_next.program_suspended_flag = 1'b1;
          end
          cur_next.ready = 1'b1;
          cur_next.rdy_event = 1'b1;
        end else if (cur_reg.op == op_dma &&
            cur_reg.words != 8'h00) begin
          cur_next.state = st_dma_wait;
          cur_next.dreq = 1'b1;
          cur_next.words = cur_reg.words - 8'h01;
        end else begin
          cur_next.state = st_idle;
          cur_next.op = op_none;
          cur_next.ready = 1'b1;
          cur_next.rdy_event = 1'b1;
        end
      end
    end
    if (cur_reg.state == st_dma_wait && dack_in) begin
      cur_next.state = st_busy;
      cur_next.timer = prog_cycles;
    end
    // bus access
    // reads answer from the first edge; writes act only at the edge
    // where the master samples waitrequest low
    if (acc || (req.write && cur_reg.ack)) begin
      cur_next.ack = acc;
      if (req.read) begin
        case (req.address)
          off_mode_entry: cur_next.rdata = {16'h0000, cur_reg.mode_entry};
          off_start_addr: cur_next.rdata = cur_reg.start_addr;
          off_end_addr: cur_next.rdata = cur_reg.end_addr;
          off_suspend_method: cur_next.rdata = {31'h0, cur_reg.esuspmd};
          off_seq_status: begin
            cur_next.rdata = 32'h0000_0000;
            cur_next.rdata[st_ready_bit] = cur_reg.ready;
            cur_next.rdata[st_suspend_ready_flag_bit] = cur_reg.suspend_ready_flag;
            cur_next.rdata[st_erase_suspended_flag_bit] = cur_reg.erase_suspended_flag;
            cur_next.rdata[st_program_suspended_flag_bit] = cur_reg.program_suspended_flag;
            cur_next.rdata[st_buf_full_bit] = 1'b0;
            cur_next.rdata[st_hv_err_bit] = cur_reg.hv_err;
            cur_next.rdata[st_ilgl_bit] = cur_reg.ilgl_err;
            cur_next.rdata[st_addr_err_bit] = cur_reg.addr_err;
          end
          off_access_status: begin
            cur_next.rdata = 32'h0000_0000;
            cur_next.rdata[st_lock_bit] = lock;
          end
          default: cur_next.rdata = 32'h0000_0000;
        endcase
      end else if (cur_reg.ack) begin
        case (req.address)
          off_mode_entry: begin
            // only the two legal codes or zero
            if (req.writedata[15:0] == mode_read ||
                req.writedata[15:0] == mode_code ||
                req.writedata[15:0] == mode_data) begin
              cur_next.mode_entry = req.writedata[15:0];
            end
            // suspended to read mode keeps suspend flags
            if (req.writedata[15:0] == mode_read &&
                (cur_reg.state == st_collect ||
                 cur_reg.state == st_wait_final)) begin
              cur_next.state = st_idle;
            end
          end
          off_start_addr: cur_next.start_addr = req.writedata;
          off_end_addr: cur_next.end_addr = req.writedata;
          off_suspend_method: cur_next.esuspmd = req.writedata[0];
          off_access_status: begin
            cur_next.hv_err = 1'b0;
            cur_next.ilgl_err = 1'b0;
            cur_next.addr_err = 1'b0;
            if (cur_reg.state == st_locked) begin
              cur_next.state = st_idle;
            end
          end
          off_cmd_area: begin
            if (!(in_code | in_data)) begin
              if (cbyte == cmd_clear) begin
                cur_next.hv_err = 1'b0;
                cur_next.ilgl_err = 1'b0;
                cur_next.addr_err = 1'b0;
              end else begin
                cur_next.ilgl_err = 1'b1;
              end
            end else if (cbyte == cmd_stop) begin
              cur_next.state = st_idle;
              cur_next.op = op_none;
              cur_next.hv_err = 1'b0;
              cur_next.ilgl_err = 1'b0;
              cur_next.addr_err = 1'b0;
              cur_next.suspend_ready_flag = 1'b0;
              cur_next.program_suspended_flag = 1'b0;
              cur_next.erase_suspended_flag = 1'b0;
              cur_next.dreq = 1'b0; // no request from an aborted run
              cur_next.ready = 1'b1;
              cur_next.rdy_event = ~cur_reg.ready;
            end else if (lock) begin
              if (cbyte == cmd_clear && cur_reg.ready) begin
                cur_next.hv_err = 1'b0;
                cur_next.ilgl_err = 1'b0;
                cur_next.addr_err = 1'b0;
                cur_next.state = st_idle;
              end
            end else begin
              case (cur_reg.state)
                st_idle, st_suspended: begin
                  if (cbyte == cmd_clear) begin
                    cur_next.hv_err = 1'b0;
                  end else if (cbyte == cmd_resume &&
                      cur_reg.state == st_suspended) begin
                    cur_next.state = st_busy;
                    cur_next.op = cur_reg.susp_op;
                    cur_next.ready = 1'b0;
                    cur_next.program_suspended_flag = 1'b0;
                    cur_next.erase_suspended_flag = 1'b0;
                    cur_next.timer = pulse_cycles + suspend_ready_flag_delay;
                  end else if (is_start(cbyte) &&
                      (in_data || cbyte == cmd_program ||
                       cbyte == cmd_blk_erase)) begin
                    // multi, dma, area only in data mode
                    cur_next.op = op_of(cbyte);
                    cur_next.words = 8'h00;
                    cur_next.state = (cbyte == cmd_blk_erase ||
                      cbyte == cmd_area_erase || cbyte == cmd_dma) ?
                      st_wait_final : st_collect;
                  end else if (cbyte == cmd_suspend &&
                      cur_reg.state == st_idle) begin
                    cur_next.state = cur_reg.state;
                  end else begin
                    cur_next.ilgl_err = 1'b1;
                    cur_next.state = st_locked;
                  end
                end
                st_collect: begin
                  // data words until the final byte
                  if (cbyte == cmd_final &&
                      cur_reg.words != 8'h00) begin
                    cur_next.state = st_busy;
                    cur_next.ready = 1'b0;
                    cur_next.timer = prog_cycles;
                  end else if (cur_reg.words != data_words_max) begin
                    cur_next.words = cur_reg.words + 8'h01;
                  end else begin
                    cur_next.ilgl_err = 1'b1;
                    cur_next.state = st_locked;
                  end
                end
                st_wait_final: begin
                  if (cbyte != cmd_final) begin
                    cur_next.ilgl_err = 1'b1;
                    cur_next.state = st_locked;
                  end else if (cur_reg.op == op_area &&
                      cur_reg.end_addr < cur_reg.start_addr) begin
                    cur_next.addr_err = 1'b1;
                    cur_next.state = st_locked;
                  end else begin
                    cur_next.ready = 1'b0;
                    if (cur_reg.op == op_dma) begin
                      cur_next.state = st_dma_wait;
                      cur_next.dreq = 1'b1;
                      cur_next.words = data_words_max;
                    end else begin
                      cur_next.state = st_busy;
                      cur_next.timer = erase_cycles;
                    end
                  end
                end
                st_busy: begin
                  if (cbyte == cmd_suspend && cur_reg.suspend_ready_flag) begin
                    cur_next.suspend_ready_flag = 1'b0;
                    cur_next.state = st_suspending;
                    if (!(is_erase(cur_reg.op) && !cur_reg.esuspmd) &&
                        cur_reg.timer > pulse_cycles) begin
                      cur_next.timer = pulse_cycles;
                    end else if (is_erase(cur_reg.op) &&
                        !cur_reg.esuspmd) begin
                      cur_next.timer = 16'h0001;
                    end
                  end else begin
                    cur_next.ilgl_err = 1'b1;
                    cur_next.state = st_locked;
                  end
                end
                default: begin
                  cur_next.ilgl_err = 1'b1;
                  cur_next.state = st_locked;
                end
              endcase
            end
          end
          default: cur_next.rdata = cur_reg.rdata;
        endcase
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cur_reg <= '{state: st_idle, op: op_none, susp_op: op_none,
        mode_entry: mode_entry_rst, start_addr: addr_rst,
        end_addr: addr_rst, ready: 1'b1, timer: 16'h0000,
        words: 8'h00, rdata: 32'h0000_0000, default: 1'b0};
    end else if (ce_in) begin
      cur_reg <= cur_next;
    end
  end

  assign avs_readdata_out = cur_reg.rdata;
  assign avs_waitrequest_out = ~cur_reg.ack;
  assign dreq_out = cur_reg.dreq;
  assign flash_ready_event_out = cur_reg.rdy_event;

  // ==========================================================
  // checks
  // lock flag follows the illegal-command error
  chk_lock_follows_err: assert property (@(posedge mclk_in) disable iff
    (rst_in) cur_reg.ilgl_err |-> lock) else $error("lock not set");
  chk_start_clears_rdy: assert property (@(posedge mclk_in) disable iff
    (rst_in) (ce_in && cur_reg.state == st_collect &&
    cur_next.state == st_busy) |=> !cur_reg.ready)
    else $error("ready not cleared");
  chk_suspended_flags: assert property (@(posedge mclk_in) disable iff
    (rst_in) cur_reg.state == st_suspended |-> cur_reg.ready &&
    (cur_reg.program_suspended_flag ^ cur_reg.erase_suspended_flag)) else $error("bad suspend");
  chk_suspend_ready_flag_drop: assert property (@(posedge mclk_in) disable iff
    (rst_in) cur_reg.state == st_suspending |-> !cur_reg.suspend_ready_flag &&
    !cur_reg.ready) else $error("suspend_ready_flag during suspend");
  chk_resume_drop: assert property (@(posedge mclk_in) disable iff
    (rst_in) ($past(cur_reg.state) == st_suspended &&
    cur_reg.state == st_busy) |-> !cur_reg.ready && !cur_reg.program_suspended_flag)
    else $error("resume flags");
  chk_ready_event: assert property (@(posedge mclk_in) disable iff
    (rst_in) $rose(cur_reg.ready) |-> cur_reg.rdy_event)
    else $error("no ready event");
  chk_locked_err: assert property (@(posedge mclk_in) disable iff
    (rst_in) cur_reg.state == st_locked |-> lock)
    else $error("locked without error");
  chk_dma_request: assert property (@(posedge mclk_in) disable iff
    (rst_in) cur_reg.dreq |-> cur_reg.state == st_dma_wait)
    else $error("stray dma request");
endmodule : flash_command_sequencer

/* File: test/dma_partner.sv */
// dma controller model: answers each transfer request with one delivery
// assumes: request is a one-cycle pulse on the sequencer clock
`timescale 1ns/100ps
module dma_partner (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic dreq_in,
  input wire logic [3:0] delay_in,
  output logic dack_out
);
  logic [3:0] cnt_reg;
  logic pend_reg;
  // ==========================================================
  // delivery after a chosen delay, prompt or slow
  // one word per request
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_reg <= 1'b0;
      cnt_reg <= 4'h0;
      dack_out <= 1'b0;
    end else begin
      dack_out <= 1'b0;
      if (dreq_in) begin
        pend_reg <= 1'b1;
        cnt_reg <= delay_in;
      end else if (pend_reg && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (pend_reg) begin
        pend_reg <= 1'b0;
        dack_out <= 1'b1;
      end
    end
  end
endmodule : dma_partner

/* File: test/flash_command_sequencer_tb.sv */
// testbench for the flash command sequencer: table rows, then commands
// assumes: package and dma_partner compiled first, avalon-mm master here
`timescale 1ns/100ps
module flash_command_sequencer_tb;
  import flash_seq_pkg::*;
  `define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
  typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic mclk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, rd = 1'b0, wr = 1'b0;
  logic wrq, dreq, dack, evt;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rdata, q;
  int fails = 0, checks = 0, events = 0, dreqs = 0, e0, i;
  row_t rows[5] = '{'{off_mode_entry, 32'h0000_0001, 32'h0000_0001},
    '{off_mode_entry, 32'h0000_0080, 32'h0000_0080},
    '{off_start_addr, 32'h0000_0100, 32'h0000_0100},
    '{off_end_addr, 32'h0000_1F00, 32'h0000_1F00},
    '{4'hF, 32'h1234_5678, 32'h0000_0000}};
  // ==========================================================
  // clock, design and dma model
  always #2.5 mclk_in = ~mclk_in;
  flash_command_sequencer u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .ce_in(ce_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wrq), .dack_in(dack), .dreq_out(dreq),
    .flash_ready_event_out(evt));
  dma_partner u_dma (.mclk_in(mclk_in), .rst_in(rst_in), .dreq_in(dreq),
    .delay_in(4'h3), .dack_out(dack));
  // pulse counters
  always @(posedge mclk_in) begin
    if (evt === 1'b1) events++;
    if (dreq === 1'b1) dreqs++;
  end
  // ==========================================================
  // bus cycle: hold until waitrequest sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge mclk_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge mclk_in); while (wrq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic cmd(input logic [7:0] c);
    bus(1'b1, off_cmd_area, {24'h00_0000, c});
  endtask : cmd
  task automatic st();
    bus(1'b0, off_seq_status, 32'h0000_0000);
  endtask : st
  // host polls with a bounded wait
  task automatic wait_bit(input int b, input logic v);
    int n = 0;
    st();
    while (q[b] !== v && n < 3000) begin
      st();
      n++;
    end
  endtask : wait_bit
  task automatic lockchk(input logic e);
    bus(1'b0, off_access_status, 32'h0000_0000);
    `CHK("lock", e, q[st_lock_bit])
  endtask : lockchk
  task automatic mode(input logic [15:0] m);
    bus(1'b1, off_mode_entry, {16'h0000, m});
  endtask : mode
  task automatic prog();
    bus(1'b1, off_start_addr, 32'h0000_0100);
    cmd(cmd_program);
    bus(1'b1, off_cmd_area, 32'hFFFF_FFFF);
    cmd(cmd_final);
  endtask : prog
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // ==========================================================
  // watchdog
  initial begin
    repeat (60000) @(posedge mclk_in);
    fails++;
    results();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    st();
    `CHK("ready", 1'b1, q[st_ready_bit])
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0000_0000);
      `CHK("row", rows[i].e, q)
    end
    $display("test rows done");
    mode(mode_read);
    cmd(cmd_program);
    lockchk(1'b1);
    cmd(cmd_clear);
    lockchk(1'b0);
    mode(mode_code);
    cmd(cmd_multi);
    lockchk(1'b1);
    cmd(cmd_stop);
    lockchk(1'b0);
    $display("test lock done");
    mode(mode_data);
    e0 = events;
    prog();
    st();
    `CHK("ready", 1'b0, q[st_ready_bit])
    `CHK("buffull", 1'b0, q[st_buf_full_bit])
    wait_bit(st_ready_bit, 1'b1);
    repeat (2) @(posedge mclk_in);
    `CHK("event", e0 + 1, events)
    prog();
    wait_bit(st_suspend_ready_flag_bit, 1'b1);
    `CHK("suspend_ready_flag", 1'b1, q[st_suspend_ready_flag_bit])
    cmd(cmd_suspend);
    wait_bit(st_ready_bit, 1'b1);
    `CHK("program_suspended_flag", 1'b1, q[st_program_suspended_flag_bit])
    `CHK("erase_suspended_flag", 1'b0, q[st_erase_suspended_flag_bit])
    lockchk(1'b0);
    cmd(cmd_resume);
    st();
    `CHK("ready", 1'b0, q[st_ready_bit])
    `CHK("program_suspended_flag", 1'b0, q[st_program_suspended_flag_bit])
    wait_bit(st_ready_bit, 1'b1);
    $display("test program done");
    cmd(cmd_resume);
    lockchk(1'b1);
    cmd(cmd_stop);
    lockchk(1'b0);
    bus(1'b1, off_start_addr, 32'h0000_2000);
    bus(1'b1, off_end_addr, 32'h0000_1000);
    cmd(cmd_area_erase);
    cmd(cmd_final);
    lockchk(1'b1);
    bus(1'b1, off_access_status, 32'h0000_0000);
    lockchk(1'b0);
    cmd(cmd_blk_erase);
    cmd(cmd_final);
    st();
    `CHK("ready", 1'b0, q[st_ready_bit])
    wait_bit(st_ready_bit, 1'b1);
    $display("test erase done");
    e0 = dreqs;
    cmd(cmd_dma);
    cmd(cmd_final);
    for (i = 0; i < 400 && dreqs < e0 + 2; i++) @(posedge mclk_in);
    `CHK("dreq", 1'b1, dreqs >= e0 + 2)
    cmd(cmd_stop);
    wait_bit(st_ready_bit, 1'b1);
    lockchk(1'b0);
    $display("test dma done");
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    bus(1'b0, off_mode_entry, 32'h0000_0000);
    `CHK("mode", 32'h0000_0000, q)
    st();
    `CHK("ready", 1'b1, q[st_ready_bit])
    $display("test reset again done");
    results();
  end
endmodule : flash_command_sequencer_tb
